// [hw/pps_top.sv]
// Port pull-up, segment select and port latch register block
`timescale 1ns/100ps
`default_nettype none

module pps_top
(
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic [15:0] CPU_ADDR,
    input wire logic CPU_WR,
    input wire logic [7:0] CPU_WDATA,
    input wire logic CPU_BIT_WR,
    input wire logic [2:0] CPU_BIT_SEL,
    input wire logic CPU_BIT_VAL,
    input wire logic CPU_RD,
    output logic [7:0] CPU_RDATA,
    input wire logic [31:0] PORT_IN_MODE,
    input wire logic [31:0] PIN_IN,
    output logic [31:0] PIN_OUT,
    output logic [31:0] PIN_OE,
    output logic [7:0] PU_EN_P6,
    output logic [7:0] PU_EN_P8,
    output logic [7:0] PU_EN_P9,
    output logic [7:0] SEG_SEL_P3,
    output logic [7:0] SEG_SEL_P4,
    output logic [7:0] SEG_SEL_P8,
    output logic [7:0] SEG_SEL_P9
);

    pps_pkg::pps_regs_t r_q;
    pps_pkg::pps_regs_t r_d;
    logic [15:0] port_addr [pps_pkg::NPORT];
    logic [7:0] seg_vec [pps_pkg::NPORT];
    logic [7:0] latch_vec [pps_pkg::NPORT];
    logic [7:0] port_rd [pps_pkg::NPORT];

    // Apply a byte or bit write to one register under its writable mask
    function automatic logic [7:0] reg_write(
        input logic [7:0] old,
        input logic [7:0] mask,
        input logic byte_en,
        input logic bit_en,
        input logic [7:0] wdata,
        input logic [2:0] sel,
        input logic val
    );
        logic [7:0] nv;
        nv = old;
        if (byte_en)
        begin
            nv = wdata;
        end
        else if (bit_en)
        begin
            nv[sel] = val;
        end
        return nv & mask;
    endfunction

    assign port_addr[0] = pps_pkg::ADDR_P3;
    assign port_addr[1] = pps_pkg::ADDR_P4;
    assign port_addr[2] = pps_pkg::ADDR_P8;
    assign port_addr[3] = pps_pkg::ADDR_P9;
    assign seg_vec[0] = r_q.pf3;
    assign seg_vec[1] = r_q.pf4;
    assign seg_vec[2] = r_q.pf8;
    assign seg_vec[3] = r_q.pf9;

    genvar gi;
    generate
        for (gi = 0; gi < pps_pkg::NPORT; gi++)
        begin : g_port
            logic hit;
            assign hit = (CPU_ADDR == port_addr[gi]);
            // Read view: latch for output pins, pin level for input pins
            assign port_rd[gi] = (latch_vec[gi] & ~PORT_IN_MODE[gi*8 +: 8])
                | (PIN_IN[gi*8 +: 8] & PORT_IN_MODE[gi*8 +: 8]);

            pps_port_latch u_latch
            (
                .clk(REF_CLK),
                .arst_n(ARST_N),
                .wr_en(hit && CPU_WR),
                .wr_data(CPU_WDATA),
                .bit_en(hit && CPU_BIT_WR),
                .bit_sel(CPU_BIT_SEL),
                .bit_val(CPU_BIT_VAL),
                .in_mode(PORT_IN_MODE[gi*8 +: 8]),
                .seg_sel(seg_vec[gi]),
                .pin_in(PIN_IN[gi*8 +: 8]),
                .latch(latch_vec[gi]),
                .pin_out(PIN_OUT[gi*8 +: 8]),
                .pin_oe(PIN_OE[gi*8 +: 8])
            );
        end
    endgenerate

    always_comb
    begin
        r_d = r_q;
        r_d.first = 1'b0;
        case (CPU_ADDR)
            pps_pkg::ADDR_PU6:
            begin
                r_d.pu6 = reg_write(r_q.pu6, pps_pkg::MASK_PU6, CPU_WR, CPU_BIT_WR,
                    CPU_WDATA, CPU_BIT_SEL, CPU_BIT_VAL);
            end
            pps_pkg::ADDR_PU8:
            begin
                r_d.pu8 = reg_write(r_q.pu8, pps_pkg::MASK_FULL, CPU_WR, CPU_BIT_WR,
                    CPU_WDATA, CPU_BIT_SEL, CPU_BIT_VAL);
            end
            pps_pkg::ADDR_PU9:
            begin
                r_d.pu9 = reg_write(r_q.pu9, pps_pkg::MASK_FULL, CPU_WR, CPU_BIT_WR,
                    CPU_WDATA, CPU_BIT_SEL, CPU_BIT_VAL);
            end
            pps_pkg::ADDR_PF3:
            begin
                r_d.pf3 = reg_write(r_q.pf3, pps_pkg::MASK_PF3, CPU_WR, CPU_BIT_WR,
                    CPU_WDATA, CPU_BIT_SEL, CPU_BIT_VAL);
            end
            pps_pkg::ADDR_PF4:
            begin
                // Bit writes are ignored; whole bytes only
                r_d.pf4 = reg_write(r_q.pf4, pps_pkg::MASK_FULL, CPU_WR, 1'b0,
                    CPU_WDATA, CPU_BIT_SEL, CPU_BIT_VAL);
            end
            pps_pkg::ADDR_PF8:
            begin
                r_d.pf8 = reg_write(r_q.pf8, pps_pkg::MASK_FULL, CPU_WR, CPU_BIT_WR,
                    CPU_WDATA, CPU_BIT_SEL, CPU_BIT_VAL);
            end
            pps_pkg::ADDR_PF9:
            begin
                r_d.pf9 = reg_write(r_q.pf9, pps_pkg::MASK_FULL, CPU_WR, CPU_BIT_WR,
                    CPU_WDATA, CPU_BIT_SEL, CPU_BIT_VAL);
            end
            default:
            begin
                r_d.first = 1'b0;
            end
        endcase
        if (CPU_RD)
        begin
            case (CPU_ADDR)
                pps_pkg::ADDR_PU6: r_d.rdata = r_q.pu6;
                pps_pkg::ADDR_PU8: r_d.rdata = r_q.pu8;
                pps_pkg::ADDR_PU9: r_d.rdata = r_q.pu9;
                pps_pkg::ADDR_PF3: r_d.rdata = r_q.pf3;
                pps_pkg::ADDR_PF4: r_d.rdata = r_q.pf4;
                pps_pkg::ADDR_PF8: r_d.rdata = r_q.pf8;
                pps_pkg::ADDR_PF9: r_d.rdata = r_q.pf9;
                pps_pkg::ADDR_P3: r_d.rdata = port_rd[0];
                pps_pkg::ADDR_P4: r_d.rdata = port_rd[1];
                pps_pkg::ADDR_P8: r_d.rdata = port_rd[2];
                pps_pkg::ADDR_P9: r_d.rdata = port_rd[3];
                default: r_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            r_q <= {pps_pkg::RST_PU, pps_pkg::RST_PU, pps_pkg::RST_PU,
                pps_pkg::RST_PF, pps_pkg::RST_PF, pps_pkg::RST_PF, pps_pkg::RST_PF,
                pps_pkg::RST_RDATA, 1'b1};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // Pull-ups follow only their enable bits, never the direction
    assign PU_EN_P6 = r_q.pu6;
    assign PU_EN_P8 = r_q.pu8;
    assign PU_EN_P9 = r_q.pu9;
    assign SEG_SEL_P3 = r_q.pf3;
    assign SEG_SEL_P4 = r_q.pf4;
    assign SEG_SEL_P8 = r_q.pf8;
    assign SEG_SEL_P9 = r_q.pf9;
    assign CPU_RDATA = r_q.rdata;

    property p_pu8_write;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (CPU_WR && CPU_ADDR == pps_pkg::ADDR_PU8) |=> (PU_EN_P8 == $past(CPU_WDATA));
    endproperty
    a_pu8_write: assert property (p_pu8_write) else $error("pull-up 8 not loaded");

    property p_pu6_low;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (PU_EN_P6 & ~pps_pkg::MASK_PU6) == 8'h00;
    endproperty
    a_pu6_low: assert property (p_pu6_low) else $error("port 6 unused pull-up set");

    property p_pu_dir_free;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (!CPU_WR && !CPU_BIT_WR) |=> $stable(PU_EN_P8) && $stable(PU_EN_P9);
    endproperty
    a_pu_dir_free: assert property (p_pu_dir_free) else $error("pull-up moved");

    property p_pf8_write;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (CPU_WR && CPU_ADDR == pps_pkg::ADDR_PF8) |=> (SEG_SEL_P8 == $past(CPU_WDATA));
    endproperty
    a_pf8_write: assert property (p_pf8_write) else $error("segment 8 not loaded");

    property p_seg_reset;
        @(posedge REF_CLK) disable iff (!ARST_N)
        r_q.first |-> (SEG_SEL_P3 == 8'h00) && (SEG_SEL_P4 == 8'h00)
            && (SEG_SEL_P8 == 8'h00) && (SEG_SEL_P9 == 8'h00);
    endproperty
    a_seg_reset: assert property (p_seg_reset) else $error("segment select not cleared");

    property p_pf4_nobit;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (CPU_BIT_WR && !CPU_WR && CPU_ADDR == pps_pkg::ADDR_PF4) |=> $stable(SEG_SEL_P4);
    endproperty
    a_pf4_nobit: assert property (p_pf4_nobit) else $error("port 4 took bit write");

    property p_pf3_low;
        @(posedge REF_CLK) disable iff (!ARST_N)
        SEG_SEL_P3[3:0] == 4'h0;
    endproperty
    a_pf3_low: assert property (p_pf3_low) else $error("port 3 low select set");

    property p_seg_oe;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (SEG_SEL_P8 != 8'h00) |=> ((PIN_OE[23:16] & $past(SEG_SEL_P8)) == 8'h00);
    endproperty
    a_seg_oe: assert property (p_seg_oe) else $error("segment pin driven by port");

    property p_port_read;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (CPU_RD && CPU_ADDR == pps_pkg::ADDR_P8)
            |=> (CPU_RDATA == $past(port_rd[2]));
    endproperty
    a_port_read: assert property (p_port_read) else $error("port read wrong");

    c_pu_bit: cover property (@(posedge REF_CLK) disable iff (!ARST_N)
        CPU_BIT_WR && CPU_ADDR == pps_pkg::ADDR_PU9);
    c_pf4_ones: cover property (@(posedge REF_CLK) disable iff (!ARST_N)
        CPU_WR && CPU_ADDR == pps_pkg::ADDR_PF4 && CPU_WDATA == 8'hff);
    c_port_wr: cover property (@(posedge REF_CLK) disable iff (!ARST_N)
        CPU_WR && CPU_ADDR == pps_pkg::ADDR_P3);

endmodule

`default_nettype wire

// [hw/pps_pkg.sv]
// Constants and state types for the port pull-up and segment select block
package pps_pkg;

    localparam int ADDR_W = 16;
    localparam int NPORT = 4;

    // Pull-up option registers
    localparam logic [15:0] ADDR_PU6 = 16'hff36;
    localparam logic [15:0] ADDR_PU8 = 16'hff38;
    localparam logic [15:0] ADDR_PU9 = 16'hff39;

    // Segment select registers
    localparam logic [15:0] ADDR_PF3 = 16'hff63;
    localparam logic [15:0] ADDR_PF4 = 16'hff64;
    localparam logic [15:0] ADDR_PF8 = 16'hff68;
    localparam logic [15:0] ADDR_PF9 = 16'hff69;

    // Port output latches, index 0..3 are ports 3, 4, 8, 9
    localparam logic [15:0] ADDR_P3 = 16'hff03;
    localparam logic [15:0] ADDR_P4 = 16'hff04;
    localparam logic [15:0] ADDR_P8 = 16'hff08;
    localparam logic [15:0] ADDR_P9 = 16'hff09;

    // Writable bit masks
    localparam logic [7:0] MASK_PU6 = 8'h3c;
    localparam logic [7:0] MASK_PF3 = 8'hf0;
    localparam logic [7:0] MASK_FULL = 8'hff;

    // Reset values
    localparam logic [7:0] RST_PU = 8'h00;
    localparam logic [7:0] RST_PF = 8'h00;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;

    typedef struct packed {
        logic [7:0] pu6;
        logic [7:0] pu8;
        logic [7:0] pu9;
        logic [7:0] pf3;
        logic [7:0] pf4;
        logic [7:0] pf8;
        logic [7:0] pf9;
        logic [7:0] rdata;
        logic first;
    } pps_regs_t;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] oe;
    } pps_latch_t;

endpackage

// [hw/pps_port_latch.sv]
// One 8-bit port output latch with byte and single-bit write paths
`timescale 1ns/100ps
`default_nettype none

module pps_port_latch
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic bit_en,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    input wire logic [7:0] in_mode,
    input wire logic [7:0] seg_sel,
    input wire logic [7:0] pin_in,
    output logic [7:0] latch,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);

    pps_pkg::pps_latch_t s_q;
    pps_pkg::pps_latch_t s_d;
    logic [7:0] rmw_byte;

    always_comb
    begin
        s_d = s_q;
        // Whole byte as the port would read: latch for outputs, pin for inputs
        rmw_byte = (s_q.latch & ~in_mode) | (pin_in & in_mode);
        rmw_byte[bit_sel] = bit_val;
        if (wr_en)
        begin
            s_d.latch = wr_data;
        end
        else if (bit_en)
        begin
            s_d.latch = rmw_byte;
        end
        // Buffer off for input pins and for pins handed to the segment driver
        s_d.oe = ~in_mode & ~seg_sel;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= {pps_pkg::RST_LATCH, 8'h00};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign latch = s_q.latch;
    assign pin_out = s_q.latch;
    assign pin_oe = s_q.oe;

    property p_byte_write;
        @(posedge clk) disable iff (!arst_n)
        wr_en |=> (latch == $past(wr_data)) && (pin_out == $past(wr_data));
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("latch missed byte write");

    property p_hold;
        @(posedge clk) disable iff (!arst_n)
        (!wr_en && !bit_en) |=> $stable(latch);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed without write");

    property p_input_off;
        @(posedge clk) disable iff (!arst_n)
        (in_mode != 8'h00) |=> ((pin_oe & $past(in_mode)) == 8'h00);
    endproperty
    a_input_off: assert property (p_input_off) else $error("buffer on for input pin");

    property p_bit_rmw;
        @(posedge clk) disable iff (!arst_n)
        (bit_en && !wr_en) |=> (latch[$past(bit_sel)] == $past(bit_val))
            && (((latch ^ $past(latch)) & ~$past(in_mode) & ~(8'h01 << $past(bit_sel)))
            == 8'h00);
    endproperty
    a_bit_rmw: assert property (p_bit_rmw) else $error("bit write disturbed outputs");

    c_bit_mixed: cover property (@(posedge clk) disable iff (!arst_n)
        bit_en && (in_mode != 8'h00) && (in_mode != 8'hff));

endmodule

`default_nettype wire

// [dv/pps_pin_model.sv]
// Board-side model of the port pins: pin drivers, external sources and pull-ups
`timescale 1ns/100ps
`default_nettype none

module pps_pin_model
(
    input wire logic clk,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [7:0] pu_p8,
    input wire logic [7:0] pu_p9,
    input wire logic [31:0] ext_en,
    input wire logic [31:0] ext_val,
    output var logic [31:0] pin_in
);
    logic [31:0] pull;

    assign pull = {pu_p9, pu_p8, 16'h0000};

    initial pin_in = 32'h00000000;

    // A pin that nobody drives and nothing pulls shows no stable level
    always @(posedge clk)
    begin
        for (int i = 0; i < 32; i++)
        begin
            if (pin_oe[i])
                pin_in[i] <= pin_out[i];
            else if (ext_en[i])
                pin_in[i] <= ext_val[i];
            else if (pull[i])
                pin_in[i] <= 1'b1;
            else
                pin_in[i] <= ~pin_in[i];
        end
    end
endmodule

`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the port pull-up, segment select and latch block
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic REF_CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic [15:0] CPU_ADDR = 16'h0000;
    logic CPU_WR = 1'b0;
    logic [7:0] CPU_WDATA = 8'h00;
    logic CPU_BIT_WR = 1'b0;
    logic [2:0] CPU_BIT_SEL = 3'h0;
    logic CPU_BIT_VAL = 1'b0;
    logic CPU_RD = 1'b0;
    logic [7:0] CPU_RDATA;
    logic [31:0] PORT_IN_MODE = 32'hffffffff;
    logic [31:0] PIN_IN, PIN_OUT, PIN_OE;
    logic [7:0] PU_EN_P6, PU_EN_P8, PU_EN_P9;
    logic [7:0] SEG_SEL_P3, SEG_SEL_P4, SEG_SEL_P8, SEG_SEL_P9;
    logic [31:0] ext_en = 32'hffffffff;
    logic [31:0] ext_val = 32'h00000000;
    logic [31:0] seed = 32'h0000a02d;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    int err_total = 0;
    int checked = 0;
    logic [15:0] port_addr [4];
    logic [15:0] reg_addr [7];
    logic [7:0] lat [4];
    logic [7:0] d, m, v;

    always #25 REF_CLK = ~REF_CLK;

    pps_top uut
    (
        .REF_CLK(REF_CLK), .ARST_N(ARST_N), .CPU_ADDR(CPU_ADDR), .CPU_WR(CPU_WR),
        .CPU_WDATA(CPU_WDATA), .CPU_BIT_WR(CPU_BIT_WR), .CPU_BIT_SEL(CPU_BIT_SEL),
        .CPU_BIT_VAL(CPU_BIT_VAL), .CPU_RD(CPU_RD), .CPU_RDATA(CPU_RDATA),
        .PORT_IN_MODE(PORT_IN_MODE), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
        .PU_EN_P6(PU_EN_P6), .PU_EN_P8(PU_EN_P8), .PU_EN_P9(PU_EN_P9),
        .SEG_SEL_P3(SEG_SEL_P3), .SEG_SEL_P4(SEG_SEL_P4), .SEG_SEL_P8(SEG_SEL_P8),
        .SEG_SEL_P9(SEG_SEL_P9)
    );

    pps_pin_model pins
    (
        .clk(REF_CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pu_p8(PU_EN_P8),
        .pu_p9(PU_EN_P9), .ext_en(ext_en), .ext_val(ext_val), .pin_in(PIN_IN)
    );

    function automatic logic [31:0] rnd_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic rnd8(output logic [7:0] r);
        seed = rnd_step(seed);
        r = seed[7:0];
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] dat);
        @(posedge REF_CLK);
        CPU_ADDR <= a;
        CPU_WDATA <= dat;
        CPU_WR <= 1'b1;
        @(posedge REF_CLK);
        CPU_WR <= 1'b0;
        @(negedge REF_CLK);
    endtask

    task automatic bwr(input logic [15:0] a, input logic [2:0] s, input logic b);
        @(posedge REF_CLK);
        CPU_ADDR <= a;
        CPU_BIT_SEL <= s;
        CPU_BIT_VAL <= b;
        CPU_BIT_WR <= 1'b1;
        @(posedge REF_CLK);
        CPU_BIT_WR <= 1'b0;
        @(negedge REF_CLK);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge REF_CLK);
        CPU_ADDR <= a;
        CPU_RD <= 1'b1;
        exp_q.push_back(e);
        @(posedge REF_CLK);
        CPU_RD <= 1'b0;
        @(negedge REF_CLK);
    endtask

    // Read data is due one cycle after the read is taken
    always @(posedge REF_CLK)
        rd_seen <= CPU_RD;

    always @(negedge REF_CLK)
    begin
        if (rd_seen && exp_q.size() > 0)
            chk(CPU_RDATA, exp_q.pop_front());
    end

    task automatic final_report;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge REF_CLK);
        err_total++;
        $display("ERROR %0t watchdog expired", $time);
        final_report();
    end

    initial
    begin
        port_addr = '{pps_pkg::ADDR_P3, pps_pkg::ADDR_P4, pps_pkg::ADDR_P8, pps_pkg::ADDR_P9};
        reg_addr = '{pps_pkg::ADDR_PU6, pps_pkg::ADDR_PU8, pps_pkg::ADDR_PU9, pps_pkg::ADDR_PF3,
                     pps_pkg::ADDR_PF4, pps_pkg::ADDR_PF8, pps_pkg::ADDR_PF9};
        repeat (12) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(reg_addr[i], 8'h00);
        chk(SEG_SEL_P4, 8'h00);
        // Byte writes to every port latch under random directions
        @(posedge REF_CLK);
        seed = rnd_step(seed);
        PORT_IN_MODE <= seed;
        ext_val <= ~seed ^ 32'h3c3c3c3c;
        for (int i = 0; i < 4; i++)
        begin
            rnd8(lat[i]);
            wr(port_addr[i], lat[i]);
            m = PORT_IN_MODE[8*i+:8];
            v = ext_val[8*i+:8];
            chk(PIN_OUT[8*i+:8], lat[i]);
            chk(PIN_OE[8*i+:8], ~m);
            rd(port_addr[i], (lat[i] & ~m) | (v & m));
        end
        for (int i = 0; i < 4; i++)
            chk(PIN_OUT[8*i+:8], lat[i]);
        // Bit writes on a mixed-direction port
        @(posedge REF_CLK);
        PORT_IN_MODE[7:0] <= 8'h5a;
        m = 8'h5a;
        // Let the buffers and the pin levels follow the new directions
        repeat (2) @(posedge REF_CLK);
        for (int s = 0; s < 8; s++)
        begin
            rnd8(v);
            bwr(pps_pkg::ADDR_P3, s[2:0], v[0]);
            lat[0] = (lat[0] & ~m) | (ext_val[7:0] & m);
            lat[0][s] = v[0];
            chk(PIN_OUT[7:0], lat[0]);
        end
        // Pull-up enables
        rnd8(d);
        wr(pps_pkg::ADDR_PU9, d);
        chk(PU_EN_P9, d);
        rd(pps_pkg::ADDR_PU9, d);
        bwr(pps_pkg::ADDR_PU9, 3'h0, ~d[0]);
        chk(PU_EN_P9, {d[7:1], ~d[0]});
        wr(pps_pkg::ADDR_PU6, 8'hff);
        chk(PU_EN_P6, 8'h3c);
        wr(pps_pkg::ADDR_PU8, 8'hff);
        @(posedge REF_CLK);
        PORT_IN_MODE[23:16] <= 8'hff;
        ext_en[23:16] <= 8'h00;
        repeat (3) @(posedge REF_CLK);
        rd(pps_pkg::ADDR_P8, 8'hff);
        @(posedge REF_CLK);
        PORT_IN_MODE[23:16] <= 8'h00;
        rd(pps_pkg::ADDR_PU8, 8'hff);
        chk(PU_EN_P8, 8'hff);
        wr(pps_pkg::ADDR_PU8, 8'h00);
        chk(PU_EN_P8, 8'h00);
        // Segment selection
        wr(pps_pkg::ADDR_PF3, 8'hff);
        chk(SEG_SEL_P3, 8'hf0);
        wr(pps_pkg::ADDR_PF4, 8'hff);
        bwr(pps_pkg::ADDR_PF4, 3'h2, 1'b0);
        chk(SEG_SEL_P4, 8'hff);
        chk(PIN_OE[15:8], 8'h00);
        wr(pps_pkg::ADDR_PF4, 8'h00);
        @(negedge REF_CLK);
        chk(PIN_OE[15:8], ~PORT_IN_MODE[15:8]);
        wr(pps_pkg::ADDR_PF8, 8'h81);
        chk(SEG_SEL_P8, 8'h81);
        bwr(pps_pkg::ADDR_PF8, 3'h5, 1'b1);
        chk(SEG_SEL_P8, 8'ha1);
        wr(pps_pkg::ADDR_PF9, 8'ha5);
        chk(SEG_SEL_P9, 8'ha5);
        @(negedge REF_CLK);
        chk(PIN_OE[31:24], ~PORT_IN_MODE[31:24] & 8'h5a);
        rd(pps_pkg::ADDR_PF3, 8'hf0);
        rd(pps_pkg::ADDR_PF8, 8'ha1);
        // Unmapped place is ignored and reads as zero
        wr(16'hff7f, 8'hff);
        rd(16'hff7f, 8'h00);
        // Give the read checker its last compare before the verdict
        @(posedge REF_CLK);
        final_report();
    end
endmodule

`default_nettype wire
